// >>> hdl/seq_pkg.sv
// Purpose: shared constants and types for the triple buck sequencer
// Assumes: 200 MHz clk_sys, comparator results synchronous to it
// Notes:   offsets are byte addresses on a 32-bit AHB-Lite bus
//
// Summary of operation
// - power good floats once all conditions met
// - window exit or low delay pin pulls low
// - uvlo, thermal, enable low, soft-start hold low
// - delay ends at good-delay threshold crossing
// - deglitch both edges over 256 switch cycles
// - enable starts channel, low enable stops it
// - enable pin defaults enabled, open-drain drive
// - input undervoltage disables every channel
// - fixed soft-start precedes power-good monitoring
// - good only after regulation and delay
// - auto sequencing needs tied mode, enable
// - floating mode gives independent channel control
// - third enable starts and stops sequence
// - interval steps at 0.75 V, 1.5 V
// - grounded mode orders 123, 213, 231
// - high mode orders 132, 312, 321
// - low bootstrap forces refresh low side
package seq_pkg;

  // ==========================================================
  // timing
  localparam int CLK_FREQ_MHZ      = 200;
  localparam int SOFT_START_US     = 2400;
  localparam int SS_CYCLES         = SOFT_START_US * CLK_FREQ_MHZ;
  localparam int PG_DEGLITCH_TICKS = 256;

  // ==========================================================
  // register map
  localparam logic [31:0] ADDR_CTRL     = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS   = 32'h0000_0004;
  localparam logic [31:0] ADDR_IRQ_STAT = 32'h0000_0008;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h0000_000C;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET    = 32'h0000_0000;
  localparam int CTRL_HOLD_BIT = 0;

  // status fields
  localparam int ST_CHAN_ON = 0;
  localparam int ST_SS_DONE = 3;
  localparam int ST_IN_WIN  = 6;
  localparam int ST_BOOT    = 9;
  localparam int ST_PGOOD   = 12;
  localparam int ST_PG_PIN  = 13;
  localparam int ST_MODE    = 14;
  localparam int ST_SEQ     = 16;

  // interrupt bits
  localparam int IRQ_PG_RISE  = 0;
  localparam int IRQ_PG_FALL  = 1;
  localparam int IRQ_UVLO     = 2;
  localparam int IRQ_THERMAL  = 3;
  localparam int IRQ_BOOT     = 4;
  localparam int IRQ_SEQ_DONE = 5;
  localparam int IRQ_W        = 6;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MODE_GND   = 2'b00,
    MODE_HIGH  = 2'b01,
    MODE_FLOAT = 2'b10
  } mode_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_UP   = 2'b01,
    SEQ_RUN  = 2'b10,
    SEQ_DOWN = 2'b11
  } seq_state_t;

  // feedback window comparators of one channel
  typedef struct packed {
    logic overLowSet;    // above 95 %
    logic underHighSet;  // below 105 %
    logic underLowClr;   // below 92.5 %
    logic overHighClr;   // above 107.5 %
  } fb_cmp_t;

endpackage

// >>> hdl/pg_deglitch.sv
// Purpose: two-sided deglitch of a level on switching clock ticks
// Assumes: tick is a one-cycle pulse per switching period
// Notes:   output follows only after TICKS steady ticks
`timescale 1ns/1ps
module pg_deglitch #(
  parameter int TICKS = seq_pkg::PG_DEGLITCH_TICKS
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // level in, filtered level out
  input  wire logic tick,
  input  wire logic levelIn,
  output logic      levelOut
);

  localparam int CW = $clog2(TICKS + 1);

  logic [CW-1:0] cnt_reg;

  // ==========================================================
  // filter
  // both edges filtered
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_reg  <= '0;
      levelOut <= 1'b0;
    end else if (levelIn == levelOut) begin
      cnt_reg <= '0;
    end else if (tick) begin
      if (cnt_reg == CW'(TICKS - 1)) begin
        cnt_reg  <= '0;
        levelOut <= levelIn;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_edge_on_tick;
    !$stable(levelOut) |-> $past(tick) && $past(cnt_reg) == CW'(TICKS - 1);
  endproperty
  a_edge_on_tick: assert property (p_edge_on_tick)
    else $error("filtered level moved before full count");

endmodule // pg_deglitch

// >>> hdl/triple_buck_sequencer_power_good.sv
// Purpose: sequencing and power-good supervision of three buck channels
// Assumes: analogue comparator results arrive synchronous to clk_sys
// Notes:   registers on AHB-Lite, zero wait state, always OKAY
//
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module triple_buck_sequencer_power_good #(
  parameter int SS_CYCLES = seq_pkg::SS_CYCLES,
  parameter int PG_TICKS  = seq_pkg::PG_DEGLITCH_TICKS
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  // interrupt
  output logic                        irq,
  // supervisor comparators
  input  wire logic                   swTick,
  input  wire logic                   uvloLow,
  input  wire logic                   thermalTrip,
  // enables and mode select
  input  wire logic [2:0]             enIn,
  input  wire logic                   modeHigh,
  input  wire logic                   modeLow,
  output logic [2:0]                  enHystOn,
  // per channel feedback and bootstrap
  input  wire seq_pkg::fb_cmp_t [2:0] fbCmp,
  input  wire logic [2:0]             bootLow,
  // capacitor timers
  input  wire logic                   pgDlyAbove,
  input  wire logic                   seqTh1,
  input  wire logic                   seqTh2,
  output logic                        pgDlyCharge,
  output logic                        seqCharge,
  // channel drive
  output logic [2:0]                  chanOn,
  output logic [2:0]                  forceLowSide,
  // open-drain power good
  input  wire logic                   pgoodIn,
  output logic                        pgoodOut,
  output logic                        pgoodOe
);

  localparam int SW      = $clog2(SS_CYCLES + 1);
  localparam int IRQ_W_T = seq_pkg::IRQ_W;

  seq_pkg::mode_t      mode_reg;
  seq_pkg::seq_state_t seqState_reg;
  logic [1:0]  step_reg;
  logic [5:0]  order_reg;
  logic [5:0]  orderSel;
  logic [2:0]  chanOn_reg;
  logic        seqDone_reg;
  logic [2:0]  ssDone;
  logic [2:0]  inWin;
  logic [31:0] ctrl_reg;
  logic [31:0] mask_reg;
  logic [IRQ_W_T-1:0] stat_reg;
  logic        inhibit;
  logic        reservedSel;
  logic        regOk;
  logic        pgDecide;
  logic        pgood;
  logic        pgPrev_reg;
  logic        uvloPrev_reg;
  logic        thermPrev_reg;
  logic [2:0]  bootPrev_reg;
  logic [IRQ_W_T-1:0] events;

  // ==========================================================
  // order selection
  // grounded and high mode orders
  always_comb begin
    orderSel = 6'b10_01_00;
    if (mode_reg == seq_pkg::MODE_HIGH) begin
      if (enIn[0] && enIn[1]) orderSel = 6'b01_10_00;
      else if (enIn[1])       orderSel = 6'b01_00_10;
      else                    orderSel = 6'b00_01_10;
    end else begin
      if (enIn[0] && enIn[1]) orderSel = 6'b10_01_00;
      else if (enIn[1])       orderSel = 6'b10_00_01;
      else                    orderSel = 6'b00_10_01;
    end
  end

  function automatic logic [2:0] slotBit(logic [5:0] ord, logic [1:0] s);
    logic [1:0] ch;
    ch = ord[2*s +: 2];
    return 3'b001 << ch;
  endfunction

  // reserved when both select enables low
  assign reservedSel = !enIn[0] && !enIn[1];
  assign inhibit = uvloLow | thermalTrip | ctrl_reg[seq_pkg::CTRL_HOLD_BIT];

  // ==========================================================
  // mode sampling
  // resampled only while idle and off
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mode_reg <= seq_pkg::MODE_FLOAT;
    end else if (chanOn_reg == 3'b000 && seqState_reg == seq_pkg::SEQ_IDLE) begin
      if (modeHigh)     mode_reg <= seq_pkg::MODE_HIGH;
      else if (modeLow) mode_reg <= seq_pkg::MODE_GND;
      else              mode_reg <= seq_pkg::MODE_FLOAT;
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      seqState_reg <= seq_pkg::SEQ_IDLE;
      step_reg     <= 2'd0;
      order_reg    <= 6'b10_01_00;
      chanOn_reg   <= 3'b000;
      seqDone_reg  <= 1'b0;
    end else begin
      seqDone_reg <= 1'b0;
      if (inhibit) begin
        seqState_reg <= seq_pkg::SEQ_IDLE;
        step_reg     <= 2'd0;
        chanOn_reg   <= 3'b000;
      end else if (mode_reg == seq_pkg::MODE_FLOAT) begin
        chanOn_reg   <= enIn;
        seqState_reg <= seq_pkg::SEQ_IDLE;
        step_reg     <= 2'd0;
      end else begin
        case (seqState_reg)
          seq_pkg::SEQ_IDLE: begin
            if (enIn[2] && !reservedSel) begin
              order_reg    <= orderSel;
              chanOn_reg   <= slotBit(orderSel, 2'd0);
              step_reg     <= 2'd1;
              seqState_reg <= seq_pkg::SEQ_UP;
            end else begin
              // leftovers from a same-edge float-to-auto switch go off
              chanOn_reg <= 3'b000;
            end
          end
          seq_pkg::SEQ_UP: begin
            if (step_reg == 2'd1 && seqTh1) begin
              chanOn_reg <= chanOn_reg | slotBit(order_reg, 2'd1);
              step_reg   <= 2'd2;
            end else if (step_reg == 2'd2 && seqTh2) begin
              chanOn_reg   <= chanOn_reg | slotBit(order_reg, 2'd2);
              step_reg     <= 2'd0;
              seqState_reg <= seq_pkg::SEQ_RUN;
              seqDone_reg  <= 1'b1;
            end
          end
          seq_pkg::SEQ_RUN: begin
            if (!enIn[2]) begin
              chanOn_reg   <= chanOn_reg & ~slotBit(order_reg, 2'd2);
              step_reg     <= 2'd1;
              seqState_reg <= seq_pkg::SEQ_DOWN;
            end
          end
          default: begin
            if (step_reg == 2'd1 && seqTh1) begin
              chanOn_reg <= chanOn_reg & ~slotBit(order_reg, 2'd1);
              step_reg   <= 2'd2;
            end else if (step_reg == 2'd2 && seqTh2) begin
              chanOn_reg   <= 3'b000;
              step_reg     <= 2'd0;
              seqState_reg <= seq_pkg::SEQ_IDLE;
              seqDone_reg  <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // cap discharges between sequences so each sequence restarts at 0 V
  always_ff @(posedge clk_sys) begin
    if (sys_rst) seqCharge <= 1'b0;
    else         seqCharge <= (step_reg != 2'd0) && !inhibit;
  end

  assign chanOn = chanOn_reg;

  // ==========================================================
  // per channel soft-start, window, bootstrap
  for (genvar i = 0; i < 3; i++) begin : g_chan
    logic [SW-1:0] ssCnt_reg;
    logic          ssDone_reg;
    logic          inWin_reg;
    logic          forceLs_reg;

    always_ff @(posedge clk_sys) begin
      if (sys_rst || !chanOn_reg[i]) begin
        ssCnt_reg  <= '0;
        ssDone_reg <= 1'b0;
      end else if (!ssDone_reg) begin
        if (ssCnt_reg == SW'(SS_CYCLES - 1)) ssDone_reg <= 1'b1;
        else                                  ssCnt_reg  <= ssCnt_reg + 1'b1;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (sys_rst) inWin_reg <= 1'b0;
      else if (fbCmp[i].underLowClr || fbCmp[i].overHighClr)
        inWin_reg <= 1'b0;
      else if (fbCmp[i].overLowSet && fbCmp[i].underHighSet)
        inWin_reg <= 1'b1;
    end

    always_ff @(posedge clk_sys) begin
      if (sys_rst) forceLs_reg <= 1'b0;
      else         forceLs_reg <= chanOn_reg[i] && bootLow[i];
    end

    assign ssDone[i]       = ssDone_reg;
    assign inWin[i]        = inWin_reg;
    assign forceLowSide[i] = forceLs_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) enHystOn <= 3'b000;
    else         enHystOn <= enIn;
  end

  // ==========================================================
  // power good
  // enables, soft-start, faults hold low
  assign regOk = (&inWin) && (&ssDone) && (&chanOn_reg) && (&enIn)
               && !uvloLow && !thermalTrip;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) pgDlyCharge <= 1'b0;
    else         pgDlyCharge <= regOk;
  end
  assign pgDecide = regOk && pgDlyAbove;

  pg_deglitch #(
    .TICKS    (PG_TICKS)
  ) u_pg_deglitch (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .tick     (swTick),
    .levelIn  (pgDecide),
    .levelOut (pgood)
  );

  // open drain: pull low unless good
  assign pgoodOut = 1'b0;
  assign pgoodOe  = !pgood;

  // ==========================================================
  // events and interrupt
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pgPrev_reg    <= 1'b0;
      uvloPrev_reg  <= 1'b0;
      thermPrev_reg <= 1'b0;
      bootPrev_reg  <= 3'b000;
    end else begin
      pgPrev_reg    <= pgood;
      uvloPrev_reg  <= uvloLow;
      thermPrev_reg <= thermalTrip;
      bootPrev_reg  <= forceLowSide;
    end
  end

  always_comb begin
    events = '0;
    events[seq_pkg::IRQ_PG_RISE]  = pgood && !pgPrev_reg;
    events[seq_pkg::IRQ_PG_FALL]  = !pgood && pgPrev_reg;
    events[seq_pkg::IRQ_UVLO]     = uvloLow && !uvloPrev_reg;
    events[seq_pkg::IRQ_THERMAL]  = thermalTrip && !thermPrev_reg;
    events[seq_pkg::IRQ_BOOT]     = |(forceLowSide & ~bootPrev_reg);
    events[seq_pkg::IRQ_SEQ_DONE] = seqDone_reg;
  end

  assign irq = |(stat_reg & mask_reg[IRQ_W_T-1:0]);

  // ==========================================================
  // ahb-lite slave
  logic        wrPend_reg;
  logic [31:0] wrAddr_reg;
  logic        take;
  logic [31:0] rdMux;

  assign take      = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb begin
    rdMux = 32'h0000_0000;
    if (haddr == seq_pkg::ADDR_CTRL) begin
      rdMux = ctrl_reg;
    end else if (haddr == seq_pkg::ADDR_STATUS) begin
      rdMux[seq_pkg::ST_CHAN_ON +: 3] = chanOn_reg;
      rdMux[seq_pkg::ST_SS_DONE +: 3] = ssDone;
      rdMux[seq_pkg::ST_IN_WIN +: 3]  = inWin;
      rdMux[seq_pkg::ST_BOOT +: 3]    = forceLowSide;
      rdMux[seq_pkg::ST_PGOOD]        = pgood;
      rdMux[seq_pkg::ST_PG_PIN]       = pgoodIn;
      rdMux[seq_pkg::ST_MODE +: 2]    = mode_reg;
      rdMux[seq_pkg::ST_SEQ +: 2]     = seqState_reg;
    end else if (haddr == seq_pkg::ADDR_IRQ_STAT) begin
      rdMux[IRQ_W_T-1:0] = stat_reg;
    end else if (haddr == seq_pkg::ADDR_IRQ_MASK) begin
      rdMux = mask_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 32'h0000_0000;
      hrdata     <= 32'h0000_0000;
    end else begin
      wrPend_reg <= take && hwrite;
      if (take) wrAddr_reg <= haddr;
      if (take && !hwrite) hrdata <= rdMux;
    end
  end

  // sticky status: a new event wins over a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_reg <= seq_pkg::CTRL_RESET;
      mask_reg <= seq_pkg::MASK_RESET;
      stat_reg <= '0;
    end else begin
      if (wrPend_reg && wrAddr_reg == seq_pkg::ADDR_CTRL)
        ctrl_reg <= hwdata & 32'h0000_0001;
      if (wrPend_reg && wrAddr_reg == seq_pkg::ADDR_IRQ_MASK)
        mask_reg <= hwdata & 32'h0000_003F;
      if (wrPend_reg && wrAddr_reg == seq_pkg::ADDR_IRQ_STAT)
        stat_reg <= (stat_reg & ~hwdata[IRQ_W_T-1:0]) | events;
      else
        stat_reg <= stat_reg | events;
    end
  end

  // ==========================================================
  // assertions
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_uvlo_off;
    uvloLow |=> chanOn_reg == 3'b000;
  endproperty
  a_uvlo_off: assert property (p_uvlo_off)
    else $error("channel on during undervoltage");

  property p_pg_blocked;
    (uvloLow || thermalTrip || !(&enIn) || !(&ssDone)) |-> !pgDecide;
  endproperty
  a_pg_blocked: assert property (p_pg_blocked)
    else $error("good decision during a holding condition");

  property p_pg_rise_cause;
    $rose(pgood) |-> $past(pgDecide) && $past(pgDlyAbove);
  endproperty
  a_pg_rise_cause: assert property (p_pg_rise_cause)
    else $error("power good rose without delay and regulation");

  property p_window_drop;
    (fbCmp[0].underLowClr || fbCmp[0].overHighClr
      || fbCmp[1].underLowClr || fbCmp[1].overHighClr
      || fbCmp[2].underLowClr || fbCmp[2].overHighClr) |=> !pgDecide;
  endproperty
  a_window_drop: assert property (p_window_drop)
    else $error("decision held with feedback outside window");

  property p_indep;
    (mode_reg == seq_pkg::MODE_FLOAT && !inhibit)
      |=> chanOn_reg == $past(enIn);
  endproperty
  a_indep: assert property (p_indep)
    else $error("independent channel not following its enable");

  property p_reserved;
    (seqState_reg == seq_pkg::SEQ_IDLE && mode_reg != seq_pkg::MODE_FLOAT
      && reservedSel) |=> seqState_reg == seq_pkg::SEQ_IDLE;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("sequence started with reserved selection");

  property p_step1;
    (seqState_reg == seq_pkg::SEQ_UP && step_reg == 2'd1 && seqTh1
      && !inhibit) |=> step_reg == 2'd2 && $countones(chanOn_reg) == 2;
  endproperty
  a_step1: assert property (p_step1)
    else $error("second channel missed first interval threshold");

  property p_boot;
    (chanOn_reg[1] && bootLow[1]) |=> forceLowSide[1];
  endproperty
  a_boot: assert property (p_boot)
    else $error("no bootstrap refresh on low bootstrap");

  property p_mode_hold;
    (chanOn_reg != 3'b000) |=> $stable(mode_reg);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode changed while channels active");

  property p_ss_clear;
    !chanOn_reg[2] |=> !ssDone[2];
  endproperty
  a_ss_clear: assert property (p_ss_clear)
    else $error("soft-start done while channel off");

  c_pg_rise: cover property ($rose(pgood));
  c_seq_up: cover property (seqState_reg == seq_pkg::SEQ_UP
    ##1 seqState_reg == seq_pkg::SEQ_RUN);
  c_seq_down: cover property (seqState_reg == seq_pkg::SEQ_DOWN
    ##1 seqState_reg == seq_pkg::SEQ_IDLE);
  c_boot: cover property ($rose(forceLowSide[0]));

endmodule // triple_buck_sequencer_power_good

// >>> bench/triple_buck_sequencer_power_good_bench.sv
// Purpose: self-checking bench for the triple buck sequencer
// Assumes: short soft-start and deglitch counts, zero wait bus
// Notes:   swTick pulses every fourth clock to keep deglitch short
`timescale 1ns/1ps
module triple_buck_sequencer_power_good_bench;
  // ==========================================================
  // signals
  localparam int SS  = 50;
  localparam int PGT = 4;
  localparam int DG  = 40;
  logic                   clk_sys = 1'h0;
  logic                   sys_rst = 1'h1;
  logic                   hsel = 1'h0, hwrite = 1'h0, hready;
  logic [31:0]            haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
  logic [1:0]             htrans = 2'h0;
  logic                   hreadyout, hresp, irq, pgDlyCharge, seqCharge;
  logic [31:0]            hrdata, rd;
  logic                   swTick = 1'h0, uvloLow = 1'h0;
  logic                   thermalTrip = 1'h0, modeHigh = 1'h0;
  logic                   modeLow = 1'h0, pgDlyAbove = 1'h0;
  logic                   seqTh1 = 1'h0, seqTh2 = 1'h0;
  logic                   pgoodIn, pgoodOut, pgoodOe;
  logic [2:0]             enIn = 3'h0, bootLow = 3'h0, enHystOn;
  logic [2:0]             chanOn, forceLowSide;
  logic [1:0]             tickCnt = 2'h0;
  seq_pkg::fb_cmp_t [2:0] fbCmp = 12'h000;
  int                     numErrors = 0, checks = 0;

  // ==========================================================
  // clock, tick, bus and pin wiring
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    tickCnt <= tickCnt + 2'h1;
    swTick  <= (tickCnt == 2'h3);
  end
  assign hready  = hreadyout;
  // open-drain pin with pull-up
  assign pgoodIn = pgoodOe ? pgoodOut : 1'h1;

  triple_buck_sequencer_power_good #(.SS_CYCLES(SS), .PG_TICKS(PGT)) uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq(irq), .swTick(swTick), .uvloLow(uvloLow),
    .thermalTrip(thermalTrip), .enIn(enIn), .modeHigh(modeHigh),
    .modeLow(modeLow), .enHystOn(enHystOn), .fbCmp(fbCmp),
    .bootLow(bootLow), .pgDlyAbove(pgDlyAbove), .seqTh1(seqTh1),
    .seqTh2(seqTh2), .pgDlyCharge(pgDlyCharge), .seqCharge(seqCharge),
    .chanOn(chanOn), .forceLowSide(forceLowSide), .pgoodIn(pgoodIn),
    .pgoodOut(pgoodOut), .pgoodOe(pgoodOe)
  );

  // ==========================================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic check(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      numErrors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  // waits on hready bounded; the watchdog backs it up
  task automatic bus(input logic wr, input logic [31:0] a, wd);
    int n;
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (hready !== 1'h1 && n < 50);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (hready !== 1'h1 && n < 50);
    rd = hrdata;
    check("bus response", 32'h0000_0000, 32'(hresp));
  endtask

  task automatic print_verdict;
    if (numErrors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic regs_test;
    bus(1'h0, seq_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    check("mask reset", seq_pkg::MASK_RESET, rd);
    bus(1'h0, 32'h0000_0040, 32'h0000_0000);
    check("unmapped read", 32'h0000_0000, rd);
  endtask

  // automatic start, mode held during run, reverse shutdown
  task automatic seq_run(input logic hi, input logic [1:0] en,
                         input logic [2:0] m1, m2);
    modeHigh <= hi;
    modeLow  <= ~hi;
    cyc(2);
    enIn     <= {1'h0, en};
    cyc(4);
    enIn[2] <= 1'h1;
    cyc(3);
    check("first on", 32'(m1), 32'(chanOn));
    check("interval charge", 32'h1, 32'(seqCharge));
    seqTh1 <= 1'h1;
    cyc(3);
    check("second on", 32'(m2), 32'(chanOn));
    seqTh2 <= 1'h1;
    cyc(3);
    check("all on", 32'h7, 32'(chanOn));
    seqTh1   <= 1'h0;
    seqTh2   <= 1'h0;
    modeHigh <= 1'h0;
    modeLow  <= 1'h0;
    cyc(3);
    check("mode kept", 32'h7, 32'(chanOn));
    enIn    <= 3'h0;
    cyc(3);
    check("last off", 32'(m2), 32'(chanOn));
    seqTh1 <= 1'h1;
    cyc(3);
    check("second off", 32'(m1), 32'(chanOn));
    seqTh2 <= 1'h1;
    cyc(3);
    check("all off", 32'h0, 32'(chanOn));
    seqTh1 <= 1'h0;
    seqTh2 <= 1'h0;
    cyc(3);
  endtask

  task automatic reserved_test;
    modeLow  <= 1'h1;
    modeHigh <= 1'h0;
    enIn     <= 3'h4;
    cyc(6);
    check("reserved off", 32'h0, 32'(chanOn));
    check("reserved pg low", 32'h1, 32'(pgoodOe));
    enIn    <= 3'h0;
    modeLow <= 1'h0;
    cyc(4);
  endtask

  task automatic indep_test;
    enIn <= 3'h5;
    cyc(3);
    check("independent on", 32'h5, 32'(chanOn));
    check("hysteresis on", 32'h5, 32'(enHystOn));
    enIn <= 3'h2;
    cyc(3);
    check("independent swap", 32'h2, 32'(chanOn));
  endtask

  // power good window, delay, deglitch, boot refresh, uvlo irq
  task automatic pg_test;
    enIn       <= 3'h7;
    fbCmp      <= 12'hCCC;
    pgDlyAbove <= 1'h1;
    cyc(SS / 2);
    check("pg in soft-start", 32'h1, 32'(pgoodOe));
    cyc(SS + DG);
    check("pg released", 32'h0, 32'(pgoodOe));
    check("delay charge", 32'h1, 32'(pgDlyCharge));
    pgDlyAbove <= 1'h0;
    cyc(2);
    check("pg deglitch hold", 32'h0, 32'(pgoodOe));
    cyc(DG);
    check("pg delay low", 32'h1, 32'(pgoodOe));
    pgDlyAbove <= 1'h1;
    cyc(DG);
    check("pg back", 32'h0, 32'(pgoodOe));
    fbCmp[1] <= 4'h6;
    cyc(DG);
    check("pg window low", 32'h1, 32'(pgoodOe));
    fbCmp[1] <= 4'hC;
    cyc(DG);
    bootLow <= 3'h3;
    cyc(3);
    check("boot refresh", 32'h3, 32'(forceLowSide));
    bootLow <= 3'h0;
    bus(1'h1, seq_pkg::ADDR_IRQ_MASK, 32'(1 << seq_pkg::IRQ_UVLO));
    check("irq masked", 32'h0, 32'(irq));
    uvloLow <= 1'h1;
    cyc(3);
    check("uvlo off", 32'h0, 32'(chanOn));
    check("irq raised", 32'h1, 32'(irq));
    bus(1'h0, seq_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    check("uvlo event", 32'h1, 32'(rd[seq_pkg::IRQ_UVLO]));
    bus(1'h1, seq_pkg::ADDR_IRQ_STAT, 32'h0000_003F);
    cyc(1);
    check("irq cleared", 32'h0, 32'(irq));
    cyc(DG);
    check("pg uvlo low", 32'h1, 32'(pgoodOe));
    uvloLow <= 1'h0;
    enIn    <= 3'h6;
    cyc(3);
    check("enable low stop", 32'h6, 32'(chanOn));
    bus(1'h1, seq_pkg::ADDR_CTRL, 32'h0000_0001);
    cyc(2);
    check("hold off", 32'h0, 32'(chanOn));
    bus(1'h0, seq_pkg::ADDR_CTRL, 32'h0000_0000);
    check("hold readback", 32'h1, rd);
    bus(1'h1, seq_pkg::ADDR_CTRL, 32'h0000_0000);
    cyc(2);
    check("hold released", 32'h6, 32'(chanOn));
    thermalTrip <= 1'h1;
    cyc(2);
    check("thermal off", 32'h0, 32'(chanOn));
    thermalTrip <= 1'h0;
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    cyc(4);
    sys_rst <= 1'h0;
    cyc(1);
    check("reset chan", 32'h0, 32'(chanOn));
    check("reset pg", 32'h1, 32'(pgoodOe));
    regs_test();
    seq_run(1'h0, 2'h3, 3'h1, 3'h3);
    seq_run(1'h0, 2'h2, 3'h2, 3'h3);
    seq_run(1'h0, 2'h1, 3'h2, 3'h6);
    seq_run(1'h1, 2'h3, 3'h1, 3'h5);
    seq_run(1'h1, 2'h2, 3'h4, 3'h5);
    seq_run(1'h1, 2'h1, 3'h4, 3'h6);
    reserved_test();
    indep_test();
    pg_test();
    print_verdict();
  end

  initial begin
    cyc(20000);
    numErrors++;
    print_verdict();
  end
endmodule // triple_buck_sequencer_power_good_bench
